// ===== inc/gp_pkg.sv
/*
 * Constants for the general-purpose port: register offsets, reset values,
 * field positions, pin grouping and the AXI4-Lite response codes.
 * Assumes a 32-bit AXI4-Lite register bus and one 8-pin port.
 */
// Function
// R1: bit x of each register controls pin x
// R2: direction 0 reads the sampled pin level
// R3: option selects floating or pull-up input
// R4: input mode writes touch only the latch
// R5: option on input raises vector interrupt request
// R6: per-vector rising or falling edge select
// R7: group pins combine into one detector input
// R8: vector fetch clears the pending request
// R9: sensitivity change clears the pending request
// R10: disabled pin feeds logic 1 to detector
// R11: software enable sequence uses rising edge first
// R12: software disable sequence uses falling edge first
// R13: direction 1 drives and reads the latch
// R14: option selects push-pull or open-drain output
// R15: latch 0 drives low, 1 high or floats
// R16: alternate output overrides, pin stays readable
// R17: floating input feeds peripheral alternate input
// R18: software disables interrupt before alternate input use
// R19: software avoids read-modify-write on data register
// R20: direction/option pair encodes the four modes
// R21: pins pass two flip-flops before use
`default_nettype none

package gp_pkg;

    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int GP_PINS          = 8;
    localparam int GP_VECS          = 2;
    localparam int GP_PINS_PER_VEC  = 4;
    localparam int GP_ADDR_W        = 8;
    localparam int GP_DATA_W        = 32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [GP_ADDR_W-1:0] GP_OFF_DATA    = 8'h00;
    localparam logic [GP_ADDR_W-1:0] GP_OFF_DIR     = 8'h04;
    localparam logic [GP_ADDR_W-1:0] GP_OFF_OPT     = 8'h08;
    localparam logic [GP_ADDR_W-1:0] GP_OFF_SENSE   = 8'h0c;
    localparam logic [GP_ADDR_W-1:0] GP_OFF_PENDING = 8'h10;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [GP_PINS-1:0] GP_RST_DATA  = 8'hff;
    localparam logic [GP_PINS-1:0] GP_RST_DIR   = 8'h00;
    localparam logic [GP_PINS-1:0] GP_RST_OPT   = 8'h00;
    localparam logic [GP_VECS-1:0] GP_RST_SENSE = 2'h0;

    // sense field: bit v of the sense register, 1 = rising edge
    localparam logic GP_SENSE_RISING  = 1'b1;
    localparam logic GP_SENSE_FALLING = 1'b0;

    // detector idle level, also forced for disabled pins
    localparam logic GP_DET_IDLE = 1'b1;

    // ------------------------------------------------------------
    // AXI4-Lite responses
    // ------------------------------------------------------------
    localparam logic [1:0] GP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GP_RESP_SLVERR = 2'h2;

endpackage : gp_pkg

`default_nettype wire

// ===== hdl/gp_ext_irq.sv
/*
 * One external interrupt vector: edge detector and pending request latch.
 * Assumes the level input is already synchronised to aclk and that the
 * fetch strobe is a one-cycle pulse from the CPU on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module gp_ext_irq
    import gp_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic det_level,
    input  wire logic rise_sel,
    input  wire logic sense_clr,
    input  wire logic vec_fetch,
    output logic      pending
);

    logic prev_reg;
    logic prev_next;
    logic pend_reg;
    logic pend_next;
    logic edge_seen;

    // ------------------------------------------------------------
    // edge detection and pending latch
    // ------------------------------------------------------------
    always_comb begin
        prev_next = det_level;
        edge_seen = (rise_sel == GP_SENSE_RISING) ? (det_level & ~prev_reg)
                                                  : (~det_level & prev_reg); // R6
        // a new edge wins over a clear in the same cycle
        if (edge_seen) begin
            pend_next = 1'b1; // R5
        end else if (vec_fetch) begin
            pend_next = 1'b0; // R8
        end else if (sense_clr) begin
            pend_next = 1'b0; // R9
        end else begin
            pend_next = pend_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= GP_DET_IDLE;
            pend_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            pend_reg <= pend_next;
        end
    end

    assign pending = pend_reg;

endmodule : gp_ext_irq

`default_nettype wire

// ===== hdl/gp_port.sv
/*
 * Eight-pin general-purpose port with AXI4-Lite register access,
 * alternate-function override and two external interrupt vectors.
 * Assumes pins arrive asynchronously, alternate-function signals and the
 * vector fetch strobes come from logic on aclk, and a pad ring resolves
 * pin_out / pin_oe / pin_pullup_en into the real wire.
 */
`timescale 1ns/1ps
`default_nettype none

module gp_port
    import gp_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite slave
    input  wire logic [GP_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]           awprot,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [GP_DATA_W-1:0] wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [GP_ADDR_W-1:0] araddr,
    input  wire logic [2:0]           arprot,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [GP_DATA_W-1:0]      rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // pins
    input  wire logic [GP_PINS-1:0]   pin_in,
    output logic [GP_PINS-1:0]        pin_out,
    output logic [GP_PINS-1:0]        pin_oe,
    output logic [GP_PINS-1:0]        pin_pullup_en,
    // on-chip peripherals
    input  wire logic [GP_PINS-1:0]   alt_out_en,
    input  wire logic [GP_PINS-1:0]   alt_out,
    output logic [GP_PINS-1:0]        alt_in,
    // interrupt vectors
    input  wire logic [GP_VECS-1:0]   irq_fetch,
    output logic [GP_VECS-1:0]        irq_req
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                 aw_hold_reg;
    logic                 aw_hold_next;
    logic [GP_ADDR_W-1:0] aw_addr_reg;
    logic [GP_ADDR_W-1:0] aw_addr_next;
    logic                 w_hold_reg;
    logic                 w_hold_next;
    logic [GP_DATA_W-1:0] w_data_reg;
    logic [GP_DATA_W-1:0] w_data_next;
    logic                 w_lane0_reg;
    logic                 w_lane0_next;
    logic                 bvalid_reg;
    logic                 bvalid_next;
    logic [1:0]           bresp_reg;
    logic [1:0]           bresp_next;
    logic                 rvalid_reg;
    logic                 rvalid_next;
    logic [GP_DATA_W-1:0] rdata_reg;
    logic [GP_DATA_W-1:0] rdata_next;
    logic [1:0]           rresp_reg;
    logic [1:0]           rresp_next;

    logic [GP_PINS-1:0]   data_reg;
    logic [GP_PINS-1:0]   data_next;
    logic [GP_PINS-1:0]   dir_reg;
    logic [GP_PINS-1:0]   dir_next;
    logic [GP_PINS-1:0]   opt_reg;
    logic [GP_PINS-1:0]   opt_next;
    logic [GP_VECS-1:0]   sense_reg;
    logic [GP_VECS-1:0]   sense_next;
    logic [GP_VECS-1:0]   sense_clr;

    logic [GP_PINS-1:0]   sync1_reg;
    logic [GP_PINS-1:0]   sync2_reg;
    logic [GP_PINS-1:0]   out_reg;
    logic [GP_PINS-1:0]   out_next;
    logic [GP_PINS-1:0]   oe_reg;
    logic [GP_PINS-1:0]   oe_next;
    logic [GP_PINS-1:0]   pull_reg;
    logic [GP_PINS-1:0]   pull_next;

    logic [GP_PINS-1:0]   pin_view;
    logic [GP_PINS-1:0]   det_in;
    logic [GP_VECS-1:0]   det_level;
    logic [GP_VECS-1:0]   pending;

    logic                 do_write;
    logic                 wr_ok;
    logic [GP_DATA_W-1:0] rd_word;
    logic                 rd_ok;

    // word-aligned decode; the two low address bits are ignored
    function automatic logic hit(input logic [GP_ADDR_W-1:0] addr,
                                 input logic [GP_ADDR_W-1:0] off);
        hit = (addr[GP_ADDR_W-1:2] == off[GP_ADDR_W-1:2]);
    endfunction : hit

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_in;    // R21
            sync2_reg <= sync1_reg; // R21
        end
    end

    // peripherals always see the pin level
    assign alt_in = sync2_reg; // R17

    // ------------------------------------------------------------
    // data register view and detector inputs
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < GP_PINS; i++) begin
            // latch is returned only for a port-driven output
            if (dir_reg[i] && !alt_out_en[i]) begin
                pin_view[i] = data_reg[i]; // R13
            end else begin
                pin_view[i] = sync2_reg[i]; // R2 R16
            end
            // interrupt only for input pins with option set
            if (!dir_reg[i] && opt_reg[i]) begin
                det_in[i] = sync2_reg[i]; // R5 R20
            end else begin
                det_in[i] = GP_DET_IDLE; // R10
            end
        end
        for (int v = 0; v < GP_VECS; v++) begin
            // a low enabled pin masks the others in its group
            det_level[v] = &det_in[v*GP_PINS_PER_VEC +: GP_PINS_PER_VEC]; // R7
        end
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < GP_PINS; i++) begin // R1
            if (alt_out_en[i]) begin
                out_next[i]  = alt_out[i]; // R16
                oe_next[i]   = 1'b1;       // R16
                pull_next[i] = 1'b0;
            end else if (dir_reg[i]) begin
                out_next[i]  = data_reg[i];               // R15
                oe_next[i]   = ~data_reg[i] | opt_reg[i]; // R14 R15 R20
                pull_next[i] = 1'b0;
            end else begin
                // input: latch writes never reach the pad
                out_next[i]  = 1'b0;       // R4
                oe_next[i]   = 1'b0;       // R4
                pull_next[i] = opt_reg[i]; // R3 R20
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_reg  <= '0;
            oe_reg   <= '0;
            pull_reg <= '0;
        end else begin
            out_reg  <= out_next;
            oe_reg   <= oe_next;
            pull_reg <= pull_next;
        end
    end

    assign pin_out       = out_reg;
    assign pin_oe        = oe_reg;
    assign pin_pullup_en = pull_reg;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign awready  = ~aw_hold_reg;
    assign wready   = ~w_hold_reg;
    assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_ok    = hit(aw_addr_reg, GP_OFF_DATA) | hit(aw_addr_reg, GP_OFF_DIR)
                    | hit(aw_addr_reg, GP_OFF_OPT) | hit(aw_addr_reg, GP_OFF_SENSE)
                    | hit(aw_addr_reg, GP_OFF_PENDING);

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_lane0_next = w_lane0_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (awvalid && awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_hold_next  = 1'b1;
            w_data_next  = wdata;
            w_lane0_next = wstrb[0];
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_ok ? GP_RESP_OKAY : GP_RESP_SLVERR;
        end else if (bvalid_reg && bready) begin
            bvalid_next  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_comb begin
        data_next  = data_reg;
        dir_next   = dir_reg;
        opt_next   = opt_reg;
        sense_next = sense_reg;
        sense_clr  = '0;
        // all fields live in byte lane 0
        if (do_write && w_lane0_reg) begin
            if (hit(aw_addr_reg, GP_OFF_DATA)) begin
                data_next = w_data_reg[GP_PINS-1:0]; // R4 R13
            end
            if (hit(aw_addr_reg, GP_OFF_DIR)) begin
                dir_next = w_data_reg[GP_PINS-1:0]; // R1
            end
            if (hit(aw_addr_reg, GP_OFF_OPT)) begin
                opt_next = w_data_reg[GP_PINS-1:0]; // R1
            end
            if (hit(aw_addr_reg, GP_OFF_SENSE)) begin
                sense_next = w_data_reg[GP_VECS-1:0];
                sense_clr  = sense_reg ^ w_data_reg[GP_VECS-1:0]; // R9
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_lane0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= GP_RESP_OKAY;
            data_reg    <= GP_RST_DATA;
            dir_reg     <= GP_RST_DIR;
            opt_reg     <= GP_RST_OPT;
            sense_reg   <= GP_RST_SENSE;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_lane0_reg <= w_lane0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            data_reg    <= data_next;
            dir_reg     <= dir_next;
            opt_reg     <= opt_next;
            sense_reg   <= sense_next;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp  = bresp_reg;

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    assign arready = ~rvalid_reg;

    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        if (hit(araddr, GP_OFF_DATA)) begin
            rd_word[GP_PINS-1:0] = pin_view; // R2 R13
        end else if (hit(araddr, GP_OFF_DIR)) begin
            rd_word[GP_PINS-1:0] = dir_reg;
        end else if (hit(araddr, GP_OFF_OPT)) begin
            rd_word[GP_PINS-1:0] = opt_reg;
        end else if (hit(araddr, GP_OFF_SENSE)) begin
            rd_word[GP_VECS-1:0] = sense_reg;
        end else if (hit(araddr, GP_OFF_PENDING)) begin
            rd_word[GP_VECS-1:0] = pending;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_word;
            rresp_next  = rd_ok ? GP_RESP_OKAY : GP_RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= GP_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata  = rdata_reg;
    assign rresp  = rresp_reg;

    // ------------------------------------------------------------
    // external interrupt vectors
    // ------------------------------------------------------------
    for (genvar v = 0; v < GP_VECS; v++) begin : g_vec
        gp_ext_irq u_irq (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .det_level (det_level[v]),
            .rise_sel  (sense_reg[v]),
            .sense_clr (sense_clr[v]),
            .vec_fetch (irq_fetch[v]),
            .pending   (pending[v])
        );
    end

    assign irq_req = pending;

endmodule : gp_port

`default_nettype wire

// ===== verification/gp_checker.sv
/*
 * Port-level assertions for gp_port.
 * Assumes one clock domain and aresetn synchronous, active low.
 */
`timescale 1ns/1ps
`default_nettype none

module gp_checker
    import gp_pkg::*;
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 awvalid,
    input wire logic                 awready,
    input wire logic                 wvalid,
    input wire logic                 wready,
    input wire logic                 bvalid,
    input wire logic                 arvalid,
    input wire logic                 arready,
    input wire logic                 rvalid,
    input wire logic [GP_DATA_W-1:0] rdata,
    input wire logic [1:0]           rresp,
    input wire logic [GP_PINS-1:0]   pin_in,
    input wire logic [GP_PINS-1:0]   pin_out,
    input wire logic [GP_PINS-1:0]   pin_oe,
    input wire logic [GP_PINS-1:0]   alt_out_en,
    input wire logic [GP_PINS-1:0]   alt_out,
    input wire logic [GP_PINS-1:0]   alt_in,
    input wire logic [GP_VECS-1:0]   irq_fetch,
    input wire logic [GP_VECS-1:0]   irq_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_wr_hold;
        !awready && !wready && !bvalid;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence

    AST_WR_WALK: assert property (s_wr_take |=> s_wr_hold ##1 bvalid)
        else $error("write answer not one cycle after hold");
    AST_WR_READY: assert property (bvalid |-> awready && wready)
        else $error("write channels not reopened with response");
    AST_RD_WALK: assert property (s_rd_take |=> rvalid && !arready)
        else $error("read answer late or address still open");
    AST_RD_ERR: assert property (rvalid && rresp == GP_RESP_SLVERR |-> rdata == '0)
        else $error("error read returned data");
    AST_ALT_OVR: assert property (
        |alt_out_en |=> ((~pin_oe & $past(alt_out_en)) == '0)
                        && (((pin_out ^ $past(alt_out)) & $past(alt_out_en)) == '0))
        else $error("alternate output not driven on pin");
    AST_ALT_SYNC: assert property (
        $past(aresetn) && $past(aresetn, 2) |-> alt_in == $past(pin_in, 2))
        else $error("pin level not two flops late");
    AST_REQ_HOLD: assert property (
        awready && wready |=> ($past(irq_req) & ~$past(irq_fetch) & ~irq_req) == '0)
        else $error("pending request dropped without cause");
    AST_REQ_IDLE: assert property ($fell(irq_req[0]) |-> $past(irq_fetch[0]) || !$past(awready))
        else $error("vector request cleared without fetch or write");
endmodule : gp_checker

`default_nettype wire

// ===== verification/gp_pin_model.sv
/*
 * Pads and outside world: resolves each pin from port drive, an outside
 * driver and the pull-up. Assumes the bench drives ext_en/ext_val on aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module gp_pin_model
    import gp_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic [GP_PINS-1:0] pin_out,
    input  wire logic [GP_PINS-1:0] pin_oe,
    input  wire logic [GP_PINS-1:0] pin_pullup_en,
    input  wire logic [GP_PINS-1:0] ext_en,
    input  wire logic [GP_PINS-1:0] ext_val,
    output logic [GP_PINS-1:0]      pin_in
);
    // floating pins wander so a stale level never reads as valid
    logic [GP_PINS-1:0] wobble = 8'h5a;

    always_ff @(posedge aclk) begin
        wobble <= ~wobble;
    end

    always_comb begin
        for (int i = 0; i < GP_PINS; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = wobble[i];
        end
    end
endmodule : gp_pin_model

`default_nettype wire

// ===== verification/tb_gpio_port_with_ext_interrupt.sv
/*
 * Self-checking bench for gp_port: AXI4-Lite master tasks, pin model,
 * bound checker. Assumes gp_pkg offsets and reset values.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_port_with_ext_interrupt
    import gp_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, alt_out_en = 8'h00, alt_out = 8'h00;
    logic [7:0]  ext_en = 8'hff, ext_val = 8'hff, pin_in, pin_out, pin_oe, pin_pullup_en, alt_in;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  irq_fetch = 2'h0, irq_req, bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    int          n_fail = 0, total_checks = 0;

    always #5 aclk = ~aclk;

    gp_port dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
                 .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
                 .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe,
                 .pin_pullup_en, .alt_out_en, .alt_out, .alt_in, .irq_fetch, .irq_req);
    gp_pin_model u_pins (.aclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pin_in);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tmo(input string nm);
        n_fail++;
        $display("[ERR] %s expected answer seen none", nm);
        end_of_test();
    endtask : tmo

    task automatic cyc(input int c);
        repeat (c) @(posedge aclk);
    endtask : cyc

    task automatic ci(input logic [1:0] e);
        chk("irq_req", 32'(irq_req), 32'(e));
    endtask : ci

    // ready lines stay up once raised; legal and avoids double drives
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 20) tmo("bvalid");
        chk("bresp", 32'(bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 20) tmo("rvalid");
        chk("rdata", rdata, ed);
        chk("rresp", 32'(rresp), 32'(er));
    endtask : rd

    task automatic fetch(input logic [1:0] v);
        irq_fetch <= v;
        cyc(1);
        irq_fetch <= 2'h0;
        cyc(1);
    endtask : fetch

    task automatic t_regs();
        rd(GP_OFF_DATA, 32'hff, GP_RESP_OKAY);
        rd(GP_OFF_DIR, 32'h0, GP_RESP_OKAY);
        rd(GP_OFF_OPT, 32'h0, GP_RESP_OKAY);
        rd(GP_OFF_SENSE, 32'h0, GP_RESP_OKAY);
        wr(GP_OFF_PENDING, 32'h3, GP_RESP_OKAY);
        rd(GP_OFF_PENDING, 32'h0, GP_RESP_OKAY);
        wr(8'h14, 32'hff, GP_RESP_SLVERR);
        rd(8'h14, 32'h0, GP_RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs

    task automatic t_input();
        ext_val <= 8'ha5;
        wr(GP_OFF_DATA, 32'h3c, GP_RESP_OKAY);
        wr(GP_OFF_OPT, 32'ha5, GP_RESP_OKAY);
        cyc(2);
        chk("pin_oe", pin_oe, 8'h00);
        chk("pullup", pin_pullup_en, 8'ha5);
        chk("alt_in", alt_in, 8'ha5);
        rd(GP_OFF_DATA, 32'ha5, GP_RESP_OKAY);
        ci(2'h0);
        wr(GP_OFF_OPT, 32'h0, GP_RESP_OKAY);
        ext_val <= 8'hff;
        $display("test input done");
    endtask : t_input

    task automatic t_output();
        ext_en <= 8'h00;
        wr(GP_OFF_DIR, 32'hff, GP_RESP_OKAY);
        wr(GP_OFF_OPT, 32'h0f, GP_RESP_OKAY);
        chk("pin_out", pin_out, 8'h3c);
        wr(GP_OFF_DATA, 32'h55, GP_RESP_OKAY);
        cyc(2);
        chk("pin_out", pin_out, 8'h55);
        chk("pin_oe", pin_oe, 8'haf);
        chk("pullup", pin_pullup_en, 8'h00);
        rd(GP_OFF_DATA, 32'h55, GP_RESP_OKAY);
        alt_out_en <= 8'h12;
        alt_out <= 8'h12;
        cyc(3);
        chk("pin_out", pin_out, 8'h57);
        chk("pin_oe", pin_oe, 8'hbf);
        rd(GP_OFF_DATA, 32'h57, GP_RESP_OKAY);
        alt_out_en <= 8'h00;
        ext_en <= 8'hff;
        wr(GP_OFF_OPT, 32'h0, GP_RESP_OKAY);
        wr(GP_OFF_DIR, 32'h0, GP_RESP_OKAY);
        $display("test output done");
    endtask : t_output

    task automatic t_irq();
        wr(GP_OFF_SENSE, 32'h1, GP_RESP_OKAY);
        wr(GP_OFF_OPT, 32'h3, GP_RESP_OKAY);
        wr(GP_OFF_SENSE, 32'h0, GP_RESP_OKAY);
        ext_val <= 8'hfe;
        cyc(4);
        ci(2'h1);
        rd(GP_OFF_PENDING, 32'h1, GP_RESP_OKAY);
        fetch(2'h1);
        ci(2'h0);
        ext_val <= 8'hfc;
        wr(GP_OFF_SENSE, 32'h1, GP_RESP_OKAY);
        ext_val <= 8'hfd;
        cyc(4);
        ci(2'h0);
        ext_val <= 8'hff;
        cyc(4);
        ci(2'h1);
        wr(GP_OFF_SENSE, 32'h0, GP_RESP_OKAY);
        ci(2'h0);
        wr(GP_OFF_SENSE, 32'h1, GP_RESP_OKAY);
        ext_val <= 8'hfe;
        cyc(4);
        ci(2'h0);
        // disable without the safe falling-edge step, on purpose
        wr(GP_OFF_OPT, 32'h0, GP_RESP_OKAY);
        cyc(4);
        ci(2'h1);
        fetch(2'h1);
        ext_val <= 8'hff;
        wr(GP_OFF_SENSE, 32'h2, GP_RESP_OKAY);
        wr(GP_OFF_OPT, 32'h10, GP_RESP_OKAY);
        ext_val <= 8'hef;
        cyc(4);
        ci(2'h0);
        ext_val <= 8'hff;
        cyc(4);
        ci(2'h2);
        fetch(2'h2);
        ci(2'h0);
        wr(GP_OFF_SENSE, 32'h0, GP_RESP_OKAY);
        wr(GP_OFF_OPT, 32'h0, GP_RESP_OKAY);
        wr(GP_OFF_SENSE, 32'h2, GP_RESP_OKAY);
        $display("test irq done");
    endtask : t_irq

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // synchroniser still holds reset zeros for two edges
        cyc(2);
        t_regs();
        t_input();
        t_output();
        t_irq();
        end_of_test();
    end
endmodule : tb_gpio_port_with_ext_interrupt

bind gp_port gp_checker u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .arvalid, .arready, .rvalid, .rdata, .rresp, .pin_in, .pin_out, .pin_oe, .alt_out_en,
    .alt_out, .alt_in, .irq_fetch, .irq_req);

`default_nettype wire
